// File: simd_fp_exception_resolution.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - trapping mode raises one vector exception when any element hits an enabled cause.
// - non-trapping mode tags faulting elements with signaling NaN carrying six cause bits.
// - cause weights E 0x20, V, Z, O 0x04, U 0x02, I 0x01.
// - non-trapping mode never traps, mask still selects tagged elements.
// - a disabled exception writes its prescribed default value regardless of mode.
// - unimplemented operation is always enabled in the effective mask.
// - overflow with overflow disabled also sets inexact.
// - underflow without inexact and underflow disabled is dropped.
// - no enabled hit: cause gets all bits, destination gets result or default.
// - enabled hit while trapping: cause gets all bits, element not written.
// - enabled hit while non-trapping: cause untouched, write tagged signaling NaN.
// - cause cleared per instruction; flags update only without enabled cause.
// - the vector exception reports exception code 0x0e.
// - defaults: quiet NaN, signed infinity, rounded or overflowed result.
// - disabled overflow default follows the rounding mode.
// - default quiet NaNs are 0x7e00, 0x7fc00000, 0x7ff8000000000000.
// - default signaling NaNs carry nonzero cause bits in the low byte.
// - a NaN operand payload propagates except in compares; among NaNs of one kind the left wins.
// - signaling NaN operands raise invalid and beat quiet NaNs.
// - quieting keeps sign and payload, sets exponent and top mantissa bit.
// - without flush mode subnormal inputs or tiny results raise unimplemented.
// - flush mode replaces tiny results by signed zero; subnormal inputs are not replaced.
// - flushed tiny results raise inexact and underflow except approximate reciprocals.
// - flushed inputs raise inexact except compares; half and non-arithmetic never flush.
module simd_fp_exception_resolution (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         issue,
  input  wire logic [1:0]   fmt,
  input  wire logic [1:0]   roundMode,
  input  wire logic [4:0]   enableMask,
  input  wire logic         nontrappingMode,
  input  wire logic         flushSubnormalMode,
  input  wire logic         isCompare,
  input  wire logic         isApproxRecip,
  input  wire logic         isArith,
  input  wire logic [127:0] resultVec,
  input  wire logic [127:0] opAVec,
  input  wire logic [127:0] opBVec,
  input  wire logic [47:0]  rawCauseVec,
  input  wire logic [7:0]   laneSign,
  input  wire logic [7:0]   laneTiny,
  input  wire logic [7:0]   laneSubIn,
  input  wire logic [4:0]   flagsClear,
  output logic      [127:0] destVec,
  output logic      [7:0]   destLaneWrite,
  output logic      [5:0]   causeField,
  output logic      [4:0]   stickyFlags,
  output logic              simdFpException,
  output logic      [4:0]   excCode,
  output logic              resolveDone
);

  // ------------------------------------------------------------
  // lane slicing
  // ------------------------------------------------------------
  function automatic logic [63:0] laneGet(input logic [127:0] v, input logic [1:0] f, input int i);
    logic [127:0] t;
    t = 128'h0;
    case (f)
      simd_fp_exc_pkg::FMT_H: t = (v >> (i * 16)) & 128'hffff;
      simd_fp_exc_pkg::FMT_W: t = (v >> (i * 32)) & 128'hffff_ffff;
      default:                t = (v >> (i * 64)) & 128'hffff_ffff_ffff_ffff;
    endcase
    laneGet = t[63:0];
  endfunction : laneGet

  function automatic logic [3:0] laneCount(input logic [1:0] f);
    case (f)
      simd_fp_exc_pkg::FMT_H: laneCount = 4'h8;
      simd_fp_exc_pkg::FMT_W: laneCount = 4'h4;
      simd_fp_exc_pkg::FMT_D: laneCount = 4'h2;
      default:                laneCount = 4'h0;
    endcase
  endfunction : laneCount

  function automatic logic [7:0] laneMask(input logic [1:0] f);
    case (f)
      simd_fp_exc_pkg::FMT_H: laneMask = 8'hff;
      simd_fp_exc_pkg::FMT_W: laneMask = 8'h0f;
      simd_fp_exc_pkg::FMT_D: laneMask = 8'h03;
      default:                laneMask = 8'h00;
    endcase
  endfunction : laneMask

  logic [63:0] laneValue [simd_fp_exc_pkg::LANES];
  logic [5:0]  causeAdd  [simd_fp_exc_pkg::LANES];
  logic [7:0]  enabledHit;
  logic [7:0]  laneWrite;

  // ------------------------------------------------------------
  // per-element resolution
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < simd_fp_exc_pkg::LANES; g++)
    begin : gLane
      simd_fp_elem_resolve uElem (
        .fmt                (fmt),
        .roundMode          (roundMode),
        .enableMask         (enableMask),
        .nontrappingMode    (nontrappingMode),
        .flushSubnormalMode (flushSubnormalMode),
        .isCompare          (isCompare),
        .isApproxRecip      (isApproxRecip),
        .isArith            (isArith),
        .laneActive         (4'(g) < laneCount(fmt)),
        .rawCause           (rawCauseVec[g*6 +: 6]),
        .laneTiny           (laneTiny[g]),
        .laneSubIn          (laneSubIn[g]),
        .laneSign           (laneSign[g]),
        .result             (laneGet(resultVec, fmt, g)),
        .opA                (laneGet(opAVec, fmt, g)),
        .opB                (laneGet(opBVec, fmt, g)),
        .laneValue          (laneValue[g]),
        .causeAdd           (causeAdd[g]),
        .enabledHit         (enabledHit[g]),
        .laneWrite          (laneWrite[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // merge lanes
  // ------------------------------------------------------------
  logic [127:0] destNext;
  logic [5:0]   causeNext;
  logic         trapNext;

  always_comb
  begin
    destNext  = 128'h0;
    causeNext = 6'h0;
    for (int i = 0; i < simd_fp_exc_pkg::LANES; i++)
      causeNext = causeNext | causeAdd[i];
    case (fmt)
      simd_fp_exc_pkg::FMT_H:
        for (int i = 0; i < 8; i++)
          destNext[i*16 +: 16] = laneValue[i][15:0];
      simd_fp_exc_pkg::FMT_W:
        for (int i = 0; i < 4; i++)
          destNext[i*32 +: 32] = laneValue[i][31:0];
      default:
        for (int i = 0; i < 2; i++)
          destNext[i*64 +: 64] = laneValue[i];
    endcase
    // no lane indication is given with the trap
    trapNext = (|enabledHit) && !nontrappingMode;
  end

  // ------------------------------------------------------------
  // result registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      destVec       <= 128'h0;
      destLaneWrite <= 8'h0;
      causeField    <= 6'h0;
      resolveDone   <= 1'b0;
    end
    else
    begin
      resolveDone <= issue;
      if (issue)
      begin
        destVec       <= destNext;
        destLaneWrite <= laneWrite;
        causeField    <= causeNext;
      end
    end
  end

  // ------------------------------------------------------------
  // exception signalling
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      simdFpException <= 1'b0;
      excCode         <= 5'h0;
    end
    else
    begin
      simdFpException <= issue && trapNext;
      if (issue && trapNext)
        excCode <= simd_fp_exc_pkg::EXC_CODE_FPE;
    end
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  // a flag raised in the cycle software clears it stays set
  always_ff @(posedge mclk)
  begin
    if (rst)
      stickyFlags <= 5'h0;
    else if (issue && !(|enabledHit))
      stickyFlags <= (stickyFlags & ~flagsClear) | causeNext[4:0];
    else
      stickyFlags <= stickyFlags & ~flagsClear;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic       ntQ;
  logic [7:0] hitQ;
  logic [5:0] effEnQ;
  // lanes of the last issue; idle lanes must stay unwritten
  logic [7:0] actQ;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ntQ    <= 1'b0;
      hitQ   <= 8'h0;
      effEnQ <= 6'h0;
      actQ   <= 8'h0;
    end
    else if (issue)
    begin
      ntQ    <= nontrappingMode;
      hitQ   <= enabledHit;
      effEnQ <= {1'b1, enableMask};
      actQ   <= laneMask(fmt);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence sIssue;
    issue ##1 resolveDone;
  endsequence

  sequence sTrapDone;
    resolveDone && !ntQ && (|hitQ);
  endsequence

  sequence sNxDone;
    resolveDone && ntQ;
  endsequence

  AST_DONE_FOLLOWS: assert property (issue |=> resolveDone)
    else $error("done missing after issue");
  AST_TRAP_RAISED: assert property (sIssue ##0 sTrapDone |-> simdFpException)
    else $error("enabled hit without trap");
  AST_NO_TRAP_NX: assert property (simdFpException |-> !ntQ && (|hitQ))
    else $error("trap taken in non-trapping mode");
  AST_EXC_CODE: assert property (simdFpException |-> excCode == simd_fp_exc_pkg::EXC_CODE_FPE)
    else $error("wrong exception code");
  AST_NO_WRITE_TRAP: assert property (sTrapDone |-> (destLaneWrite & hitQ) == 8'h0)
    else $error("faulting lane written while trapping");
  AST_FLAGS_HOLD: assert property (simdFpException && $past(flagsClear) == 5'h0
                                   |-> stickyFlags == $past(stickyFlags))
    else $error("flags changed on trap");
  AST_FLAGS_SET: assert property (resolveDone && !(|hitQ)
                                  |-> (stickyFlags & causeField[4:0]) == causeField[4:0])
    else $error("cause not merged into flags");
  AST_UNIMP_ON: assert property (resolveDone |-> effEnQ[simd_fp_exc_pkg::C_E])
    else $error("unimplemented not enabled");
  AST_SNAN_TAG: assert property (resolveDone && ntQ && hitQ[0]
                                 |-> destLaneWrite[0] && destVec[5:0] != 6'h0)
    else $error("tagged lane lacks cause bits");
  AST_CAUSE_NX: assert property (resolveDone && ntQ && (hitQ | ~actQ) == 8'hff
                                 |-> causeField == 6'h0)
    else $error("tagged lanes leaked into cause");

  // ------------------------------------------------------------
  // pulse, hold and lane bound checks
  // ------------------------------------------------------------
  // a stray pulse or an idle lane write would corrupt the vector register
  AST_DONE_PULSE: assert property (!issue |=> !resolveDone)
    else $error("done without issue");
  AST_LANE_BOUND: assert property (resolveDone |-> (destLaneWrite & ~actQ) == 8'h0)
    else $error("idle lane written");
  AST_TRAP_ON_DONE: assert property (simdFpException |-> resolveDone)
    else $error("trap outside an answer");
  AST_CAUSE_TRAP: assert property (sTrapDone |-> causeField != 6'h0)
    else $error("trap with empty cause");
  AST_UNIMP_TRAP: assert property (resolveDone && !ntQ && causeField[simd_fp_exc_pkg::C_E]
                                   |-> simdFpException)
    else $error("unimplemented cause without trap");
  AST_NX_QUIET: assert property (sNxDone |-> !simdFpException)
    else $error("trap in non-trapping mode");
  AST_TAG_WRITE: assert property (sNxDone |-> (destLaneWrite & hitQ) == hitQ)
    else $error("faulting lane not tagged");
  AST_EXC_HOLD: assert property (!simdFpException |-> $stable(excCode))
    else $error("exception code moved without trap");
  AST_FLAGS_CLEAR: assert property (!issue
                                    |=> stickyFlags == ($past(stickyFlags) & ~$past(flagsClear)))
    else $error("flags moved without issue");

endmodule : simd_fp_exception_resolution
`default_nettype wire

// File: simd_fp_exc_pkg.sv
`default_nettype none
package simd_fp_exc_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int VEC_W   = 128;
  localparam int LANES   = 8;
  localparam int CAUSE_W = 6;
  localparam int FLAG_W  = 5;

  // element format codes
  localparam logic [1:0] FMT_H = 2'h1;
  localparam logic [1:0] FMT_W = 2'h2;
  localparam logic [1:0] FMT_D = 2'h3;

  // rounding mode codes
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_POS  = 2'h2;
  localparam logic [1:0] RM_NEG  = 2'h3;

  // ------------------------------------------------------------
  // cause bit positions, weights E=0x20 V Z O=0x04 U=0x02 I=0x01
  // ------------------------------------------------------------
  localparam int C_E = 5;
  localparam int C_V = 4;
  localparam int C_Z = 3;
  localparam int C_O = 2;
  localparam int C_U = 1;
  localparam int C_I = 0;

  localparam logic [4:0] EXC_CODE_FPE = 5'h0e;

  // ------------------------------------------------------------
  // default NaNs and field masks
  // ------------------------------------------------------------
  localparam logic [63:0] QNAN_H = 64'h0000_0000_0000_7e00;
  localparam logic [63:0] QNAN_W = 64'h0000_0000_7fc0_0000;
  localparam logic [63:0] QNAN_D = 64'h7ff8_0000_0000_0000;
  localparam logic [63:0] SNAN_H = 64'h0000_0000_0000_7c00;
  localparam logic [63:0] SNAN_W = 64'h0000_0000_7f80_0000;
  localparam logic [63:0] SNAN_D = 64'h7ff0_0000_0000_0000;
  localparam logic [63:0] SIGN_H = 64'h0000_0000_0000_8000;
  localparam logic [63:0] SIGN_W = 64'h0000_0000_8000_0000;
  localparam logic [63:0] SIGN_D = 64'h8000_0000_0000_0000;
  localparam logic [63:0] MAN_H  = 64'h0000_0000_0000_03ff;
  localparam logic [63:0] MAN_W  = 64'h0000_0000_007f_ffff;
  localparam logic [63:0] MAN_D  = 64'h000f_ffff_ffff_ffff;
  localparam logic [63:0] ELSB_H = 64'h0000_0000_0000_0400;
  localparam logic [63:0] ELSB_W = 64'h0000_0000_0080_0000;
  localparam logic [63:0] ELSB_D = 64'h0010_0000_0000_0000;

  // ------------------------------------------------------------
  // per-format helpers
  // ------------------------------------------------------------
  function automatic logic [63:0] qnanOf(input logic [1:0] f);
    case (f)
      FMT_H:   qnanOf = QNAN_H;
      FMT_W:   qnanOf = QNAN_W;
      default: qnanOf = QNAN_D;
    endcase
  endfunction : qnanOf

  function automatic logic [63:0] snanOf(input logic [1:0] f);
    case (f)
      FMT_H:   snanOf = SNAN_H;
      FMT_W:   snanOf = SNAN_W;
      default: snanOf = SNAN_D;
    endcase
  endfunction : snanOf

  function automatic logic [63:0] signOf(input logic [1:0] f);
    case (f)
      FMT_H:   signOf = SIGN_H;
      FMT_W:   signOf = SIGN_W;
      default: signOf = SIGN_D;
    endcase
  endfunction : signOf

  function automatic logic [63:0] manOf(input logic [1:0] f);
    case (f)
      FMT_H:   manOf = MAN_H;
      FMT_W:   manOf = MAN_W;
      default: manOf = MAN_D;
    endcase
  endfunction : manOf

  function automatic logic [63:0] elsbOf(input logic [1:0] f);
    case (f)
      FMT_H:   elsbOf = ELSB_H;
      FMT_W:   elsbOf = ELSB_W;
      default: elsbOf = ELSB_D;
    endcase
  endfunction : elsbOf

  // exponent all ones is the signalling base with the mantissa cleared
  function automatic logic isNan(input logic [1:0] f, input logic [63:0] x);
    isNan = ((x & snanOf(f)) == snanOf(f)) && ((x & manOf(f)) != 64'h0);
  endfunction : isNan

  function automatic logic isSnan(input logic [1:0] f, input logic [63:0] x);
    isSnan = isNan(f, x) && ((x & (qnanOf(f) ^ snanOf(f))) == 64'h0);
  endfunction : isSnan

  // keeps sign and payload, forces exponent ones and top mantissa bit
  function automatic logic [63:0] quietOf(input logic [1:0] f, input logic [63:0] x);
    quietOf = x | qnanOf(f);
  endfunction : quietOf

  function automatic logic [63:0] infOf(input logic [1:0] f, input logic s);
    infOf = snanOf(f) | (s ? signOf(f) : 64'h0);
  endfunction : infOf

  function automatic logic [63:0] maxFinOf(input logic [1:0] f, input logic s);
    maxFinOf = (snanOf(f) - elsbOf(f)) | manOf(f) | (s ? signOf(f) : 64'h0);
  endfunction : maxFinOf

endpackage : simd_fp_exc_pkg
`default_nettype wire

// File: simd_fp_elem_resolve.sv
`timescale 1ns/100ps
`default_nettype none
module simd_fp_elem_resolve (
  input  wire logic [1:0]  fmt,
  input  wire logic [1:0]  roundMode,
  input  wire logic [4:0]  enableMask,
  input  wire logic        nontrappingMode,
  input  wire logic        flushSubnormalMode,
  input  wire logic        isCompare,
  input  wire logic        isApproxRecip,
  input  wire logic        isArith,
  input  wire logic        laneActive,
  input  wire logic [5:0]  rawCause,
  input  wire logic        laneTiny,
  input  wire logic        laneSubIn,
  input  wire logic        laneSign,
  input  wire logic [63:0] result,
  input  wire logic [63:0] opA,
  input  wire logic [63:0] opB,
  output logic      [63:0] laneValue,
  output logic      [5:0]  causeAdd,
  output logic             enabledHit,
  output logic             laneWrite
);

  logic [5:0]  en;
  logic [5:0]  c;
  logic [5:0]  hit;
  logic [63:0] prop;
  logic [63:0] res;
  logic [63:0] dflt;
  logic        nanA;
  logic        nanB;
  logic        snA;
  logic        snB;

  always_comb
  begin
    en   = {1'b1, enableMask};
    c    = rawCause;
    nanA = simd_fp_exc_pkg::isNan(fmt, opA);
    nanB = simd_fp_exc_pkg::isNan(fmt, opB);
    snA  = simd_fp_exc_pkg::isSnan(fmt, opA);
    snB  = simd_fp_exc_pkg::isSnan(fmt, opB);
    if (snA || snB)
      c[simd_fp_exc_pkg::C_V] = 1'b1;
    // signalling operands win, then left to right
    if (snA)
      prop = simd_fp_exc_pkg::quietOf(fmt, opA);
    else if (snB)
      prop = simd_fp_exc_pkg::quietOf(fmt, opB);
    else if (nanA)
      prop = opA;
    else if (nanB)
      prop = opB;
    else
      prop = simd_fp_exc_pkg::qnanOf(fmt);
    res = (!isCompare && (nanA || nanB)) ? prop : result;
    // half precision and non arithmetic operations are never flushed
    if (flushSubnormalMode && isArith && fmt != simd_fp_exc_pkg::FMT_H)
    begin
      if (laneTiny)
      begin
        res = laneSign ? simd_fp_exc_pkg::signOf(fmt) : 64'h0;
        if (!isApproxRecip)
        begin
          c[simd_fp_exc_pkg::C_I] = 1'b1;
          c[simd_fp_exc_pkg::C_U] = 1'b1;
        end
      end
      if (laneSubIn && !isCompare)
        c[simd_fp_exc_pkg::C_I] = 1'b1;
    end
    else if (!flushSubnormalMode && (laneTiny || laneSubIn))
      c[simd_fp_exc_pkg::C_E] = 1'b1;
    if (c[simd_fp_exc_pkg::C_O] && !en[simd_fp_exc_pkg::C_O])
      c[simd_fp_exc_pkg::C_I] = 1'b1;
    if (c[simd_fp_exc_pkg::C_U] && !en[simd_fp_exc_pkg::C_U] && !c[simd_fp_exc_pkg::C_I])
      c[simd_fp_exc_pkg::C_U] = 1'b0;
    hit = c & en;
    // disabled defaults, most severe condition first
    if (c[simd_fp_exc_pkg::C_V])
      dflt = prop;
    else if (c[simd_fp_exc_pkg::C_Z])
      dflt = simd_fp_exc_pkg::infOf(fmt, laneSign);
    else if (c[simd_fp_exc_pkg::C_O])
    begin
      case (roundMode)
        simd_fp_exc_pkg::RM_NEAR: dflt = simd_fp_exc_pkg::infOf(fmt, laneSign);
        simd_fp_exc_pkg::RM_ZERO: dflt = simd_fp_exc_pkg::maxFinOf(fmt, laneSign);
        simd_fp_exc_pkg::RM_POS:  dflt = laneSign ? simd_fp_exc_pkg::maxFinOf(fmt, 1'b1)
                                                  : simd_fp_exc_pkg::infOf(fmt, 1'b0);
        default:                  dflt = laneSign ? simd_fp_exc_pkg::infOf(fmt, 1'b1)
                                                  : simd_fp_exc_pkg::maxFinOf(fmt, 1'b0);
      endcase
    end
    else
      dflt = res;
    laneValue  = 64'h0;
    causeAdd   = 6'h0;
    enabledHit = 1'b0;
    laneWrite  = 1'b0;
    if (laneActive)
    begin
      enabledHit = |hit;
      if (hit == 6'h0)
      begin
        causeAdd  = c;
        laneWrite = 1'b1;
        laneValue = (c == 6'h0) ? res : dflt;
      end
      else if (!nontrappingMode)
        causeAdd = c;
      else
      begin
        laneWrite = 1'b1;
        laneValue = simd_fp_exc_pkg::snanOf(fmt) | {58'h0, c};
      end
    end
  end

endmodule : simd_fp_elem_resolve
`default_nettype wire

// File: core_trap_model.sv
`timescale 1ns/100ps
`default_nettype none
module core_trap_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       simdFpException,
  input  wire logic [4:0] excCode,
  output logic      [7:0] trapCount,
  output logic      [7:0] badCodeCount
);
  // ----------------------------------------
  // trap intake
  // ----------------------------------------
  // excCode is loaded on the trap edge, so it is judged in the pulse cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      trapCount    <= 8'h00;
      badCodeCount <= 8'h00;
    end
    else if (simdFpException === 1'b1)
    begin
      trapCount <= trapCount + 8'h01;
      if (excCode !== simd_fp_exc_pkg::EXC_CODE_FPE)
        badCodeCount <= badCodeCount + 8'h01;
    end
  end
endmodule : core_trap_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  typedef struct {logic [127:0] dest; logic [7:0] wr; logic [5:0] cause; logic exc; logic [4:0] flags;} exp_t;
  logic mclk = 1'b0, rst = 1'b1, issue = 1'b0, nontrappingMode = 1'b0, flushSubnormalMode = 1'b0, isArith = 1'b0;
  logic isCompare = 1'b0, isApproxRecip = 1'b0, spread = 1'b0;
  logic [1:0] fmt = 2'h0, roundMode = 2'h0;
  logic [4:0] enableMask = 5'h00, flagsClear = 5'h00, expFlags = 5'h00;
  logic [127:0] resultVec = 128'h0, opAVec = 128'h0, opBVec = 128'h0, destVec;
  logic [47:0] rawCauseVec = 48'h0;
  logic [7:0] laneSign = 8'h00, laneTiny = 8'h00, laneSubIn = 8'h00, destLaneWrite, trapCount, badCodeCount;
  logic [5:0] causeField;
  logic [4:0] stickyFlags, excCode;
  logic simdFpException, resolveDone;
  logic [31:0] ovf [8] = '{32'h7f800000, 32'hff800000, 32'h7f7fffff, 32'hff7fffff,
                           32'h7f800000, 32'hff7fffff, 32'h7f7fffff, 32'hff800000};
  int err_total = 0, checks_done = 0, expTraps = 0;
  exp_t q [$];
  exp_t me;
  initial forever #12.5 mclk = ~mclk;
  simd_fp_exception_resolution dut (.mclk(mclk), .rst(rst), .issue(issue), .fmt(fmt), .roundMode(roundMode),
    .enableMask(enableMask), .nontrappingMode(nontrappingMode), .flushSubnormalMode(flushSubnormalMode),
    .isCompare(isCompare), .isApproxRecip(isApproxRecip), .isArith(isArith), .resultVec(resultVec), .opAVec(opAVec),
    .opBVec(opBVec), .rawCauseVec(rawCauseVec), .laneSign(laneSign), .laneTiny(laneTiny), .laneSubIn(laneSubIn),
    .flagsClear(flagsClear), .destVec(destVec), .destLaneWrite(destLaneWrite), .causeField(causeField),
    .stickyFlags(stickyFlags), .simdFpException(simdFpException), .excCode(excCode), .resolveDone(resolveDone));
  core_trap_model core (.mclk(mclk), .rst(rst), .simdFpException(simdFpException), .excCode(excCode),
    .trapCount(trapCount), .badCodeCount(badCodeCount));
  // ----------------------------------------
  // driver: one 32-bit instruction, lane 0 carries the case, or lanes 0 to 3 when spread is set
  // ----------------------------------------
  task automatic op(input logic [5:0] rc, input logic nx, input logic [4:0] mask, input logic [2:0] rs,
                    input logic tiny, input logic fl, input logic [31:0] a0, input logic [4:0] clr,
                    input logic [31:0] v0, input logic ur, input logic w0, input logic [5:0] cz, input logic hit);
    logic [127:0] r;
    exp_t e;
    for (int i = 0; i < 4; i++) r[i*32 +: 32] = $urandom & 32'h3fffffff;
    @(posedge mclk);
    issue <= 1'b1; fmt <= simd_fp_exc_pkg::FMT_W; roundMode <= rs[2:1]; enableMask <= mask;
    nontrappingMode <= nx; flushSubnormalMode <= fl; isArith <= tiny | 1'($urandom);
    resultVec <= r; opAVec <= {96'h0, a0}; rawCauseVec <= spread ? {24'h0, {4{rc}}} : {42'h0, rc};
    laneSign <= {7'($urandom), rs[0]}; laneTiny <= {7'h00, tiny}; flagsClear <= clr;
    expFlags = (expFlags & ~clr) | (hit ? 5'h00 : cz[4:0]);
    e.dest = spread ? {4{v0}} : {r[127:32], w0 ? (ur ? r[31:0] : v0) : 32'h0};
    e.wr = {4'h0, 3'h7, w0};
    e.cause = cz;
    e.exc = hit && !nx;
    e.flags = expFlags;
    expTraps += int'(e.exc);
    q.push_back(e);
    @(posedge mclk);
    issue <= 1'b0;
    flagsClear <= 5'h00;
  endtask : op
  // ----------------------------------------
  // monitor: oldest note against each answer
  // ----------------------------------------
  always @(negedge mclk)
  begin
    if (resolveDone === 1'b1 && q.size() > 0)
    begin
      me = q.pop_front();
      `CHK("destVec", me.dest, destVec)
      `CHK("destLaneWrite", me.wr, destLaneWrite)
      `CHK("causeField", me.cause, causeField)
      `CHK("simdFpException", me.exc, simdFpException)
      `CHK("stickyFlags", me.flags, stickyFlags)
    end
    else if (resolveDone === 1'b1 || simdFpException === 1'b1)
      `CHK("unexpected answer", 1'b0, 1'b1)
  end
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    void'($urandom(36));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("reset destVec", 128'h0, destVec)
    op(6'h00, 1'b0, 5'h1f, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h0, 1'b1, 1'b1, 6'h00, 1'b0);
    for (int k = 0; k < 8; k++)
      op(6'h04, 1'b0, 5'h00, 3'(k), 1'b0, 1'b0, 32'h0, 5'h00, ovf[k], 1'b0, 1'b1, 6'h05, 1'b0);
    op(6'h08, 1'b0, 5'h00, 3'h1, 1'b0, 1'b0, 32'h0, 5'h00, 32'hff800000, 1'b0, 1'b1, 6'h08, 1'b0);
    op(6'h10, 1'b0, 5'h10, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h0, 1'b0, 1'b0, 6'h10, 1'b1);
    op(6'h10, 1'b1, 5'h10, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h7f800010, 1'b0, 1'b1, 6'h00, 1'b1);
    op(6'h20, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h0, 1'b0, 1'b0, 6'h20, 1'b1);
    op(6'h20, 1'b1, 5'h00, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h7f800020, 1'b0, 1'b1, 6'h00, 1'b1);
    op(6'h02, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h0, 1'b1, 1'b1, 6'h00, 1'b0);
    op(6'h03, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h0, 1'b1, 1'b1, 6'h03, 1'b0);
    op(6'h00, 1'b0, 5'h00, 3'h0, 1'b1, 1'b0, 32'h0, 5'h00, 32'h0, 1'b0, 1'b0, 6'h20, 1'b1);
    op(6'h00, 1'b0, 5'h00, 3'h1, 1'b1, 1'b1, 32'h0, 5'h00, 32'h80000000, 1'b0, 1'b1, 6'h03, 1'b0);
    op(6'h00, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h7f800001, 5'h00, 32'h7fc00001, 1'b0, 1'b1, 6'h10, 1'b0);
    opBVec <= {96'h0, 32'h7f800003};
    op(6'h00, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h7fc00005, 5'h00, 32'h7fc00003, 1'b0, 1'b1, 6'h10, 1'b0);
    opBVec <= 128'h0;
    isApproxRecip <= 1'b1;
    op(6'h00, 1'b0, 5'h00, 3'h1, 1'b1, 1'b1, 32'h0, 5'h00, 32'h80000000, 1'b0, 1'b1, 6'h00, 1'b0);
    isApproxRecip <= 1'b0;
    isCompare <= 1'b1;
    laneSubIn <= 8'h01;
    op(6'h00, 1'b0, 5'h00, 3'h0, 1'b0, 1'b1, 32'h7fc00000, 5'h00, 32'h0, 1'b1, 1'b1, 6'h00, 1'b0);
    isCompare <= 1'b0;
    laneSubIn <= 8'h00;
    spread = 1'b1;
    op(6'h10, 1'b1, 5'h10, 3'h0, 1'b0, 1'b0, 32'h0, 5'h00, 32'h7f800010, 1'b0, 1'b1, 6'h00, 1'b1);
    spread = 1'b0;
    op(6'h00, 1'b0, 5'h00, 3'h0, 1'b0, 1'b0, 32'h0, 5'h1f, 32'h0, 1'b1, 1'b1, 6'h00, 1'b0);
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge mclk);
    `CHK("pending answers", 0, q.size())
    `CHK("trapCount", 8'(expTraps), trapCount)
    `CHK("badCodeCount", 8'h00, badCodeCount)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
